// file: design/dpfc_pkg.sv
package dpfc_pkg;

	// ========================================
	// Serial word layout
	localparam int         WORD_W   = 24;
	localparam logic [4:0] BIT_LAST = 5'h17;
	localparam int         RW_POS   = 23;
	localparam int         REG_HI   = 21;
	localparam int         REG_LO   = 19;
	localparam int         ADR_HI   = 18;
	localparam int         ADR_LO   = 16;
	localparam int         DAT_W    = 16;
	localparam logic [2:0] REG_DAC  = 3'h0;
	localparam logic [2:0] REG_PWR  = 3'h2;
	localparam logic [2:0] REG_CTRL = 3'h3;
	localparam logic [2:0] ADR_CH_A = 3'h0;
	localparam logic [2:0] ADR_CH_B = 3'h2;
	localparam logic [2:0] ADR_BOTH = 3'h4;
	localparam logic [2:0] ADR_CFG  = 3'h1;
	localparam logic [2:0] ADR_LOAD = 3'h5;

	// ========================================
	// Power control and configuration bits
	localparam int   PU_A     = 0;
	localparam int   PU_B     = 2;
	localparam int   VREF_POWERUP   = 4;
	localparam int   TALERT   = 5;
	localparam int   OC_A     = 7;
	localparam int   OC_B     = 9;
	localparam int   CFG_SDO  = 0;
	localparam int   CFG_CLMP = 2;
	localparam int   CFG_TSD  = 3;
	localparam logic CLMP_RST = 1'b1;
	localparam logic TSD_RST  = 1'b0;
	localparam logic SDO_RST  = 1'b0;

	// ========================================
	// Wishbone map and status bits
	localparam logic [7:0] WB_DAC_A = 8'h00;
	localparam logic [7:0] WB_DAC_B = 8'h04;
	localparam logic [7:0] WB_PWR   = 8'h08;
	localparam logic [7:0] WB_CTRL  = 8'h0c;
	localparam logic [7:0] WB_STAT  = 8'h10;
	localparam int         ST_SUP   = 0;
	localparam int         ST_OT    = 1;
	localparam int         ST_VALID = 2;
	localparam int         ST_CLAMP = 4;
	localparam int         ST_OCRAW = 6;

	typedef enum logic [1:0] {
		FR_IDLE  = 2'h0,
		FR_SHIFT = 2'h1,
		FR_DONE  = 2'h3
	} dpfc_frame_t;

endpackage : dpfc_pkg

// file: design/dpfc_serial_rx.sv
`timescale 1ns/100ps
`default_nettype none

module dpfc_serial_rx (
	input  wire logic        clk,            // System clock
	input  wire logic        rst,            // Synchronous reset
	input  wire logic        serial_clk,     // Host serial clock pin
	input  wire logic        frame_sync_n,   // Frame sync pin, low in frame
	input  wire logic        serial_data_in, // Host data pin
	input  wire logic        load_outputs_n, // Load strobe pin
	input  wire logic [23:0] tx_word,        // Readback word to send
	input  wire logic        tx_en,          // Readback output enabled
	output logic      [23:0] word,           // Last complete word
	output logic             word_stb,       // One-cycle pulse per word
	output logic             load_s,         // Synchronised load strobe
	output logic             serial_data_out // Readback data pin
);

	// ========================================
	// Pin synchronisers
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic       sck_prev_q;
	logic       sck_fall;
	logic       sck_rise;

	always_ff @(posedge clk) begin
		if (rst) begin
			// Link clock idles low; a high reset value here would fake a rising edge
			meta_q     <= 4'he;
			sync_q     <= 4'he;
			sck_prev_q <= 1'b0;
		end else begin
			meta_q     <= {load_outputs_n, serial_data_in, frame_sync_n, serial_clk};
			sync_q     <= meta_q;
			sck_prev_q <= sync_q[0];
		end
	end

	assign sck_fall = sck_prev_q & ~sync_q[0];
	assign sck_rise = ~sck_prev_q & sync_q[0];
	assign load_s   = sync_q[3];

	// ========================================
	// Frame shifter
	dpfc_pkg::dpfc_frame_t state_q;
	logic [4:0]            cnt_q;
	logic [23:0]           sr_q;
	logic [23:0]           tx_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q  <= dpfc_pkg::FR_IDLE;
			cnt_q    <= 5'h00;
			sr_q     <= 24'h000000;
			tx_q     <= 24'h000000;
			word     <= 24'h000000;
			word_stb <= 1'b0;
		end else begin
			word_stb <= 1'b0;
			case (state_q)
				dpfc_pkg::FR_IDLE: begin
					if (!sync_q[1]) begin
						state_q <= dpfc_pkg::FR_SHIFT;
						cnt_q   <= 5'h00;
						tx_q    <= tx_word;
					end
				end
				dpfc_pkg::FR_SHIFT: begin
					// A frame cut short is dropped whole
					if (sync_q[1]) begin
						state_q <= dpfc_pkg::FR_IDLE;
					end else if (sck_fall) begin
						sr_q  <= {sr_q[22:0], sync_q[2]}; // R12
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == dpfc_pkg::BIT_LAST) begin
							state_q  <= dpfc_pkg::FR_DONE;
							word     <= {sr_q[22:0], sync_q[2]};
							word_stb <= 1'b1;
						end
					end else if (sck_rise) begin
						tx_q <= {tx_q[22:0], 1'b0};
					end
				end
				dpfc_pkg::FR_DONE: begin
					// Clocks beyond the word are ignored until sync rises
					if (sync_q[1]) begin
						state_q <= dpfc_pkg::FR_IDLE;
					end
				end
				default: begin
					state_q <= dpfc_pkg::FR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			serial_data_out <= 1'b0;
		end else begin
			serial_data_out <= tx_en & (state_q == dpfc_pkg::FR_SHIFT) & tx_q[23];
		end
	end

	a_word_length: assert property (@(posedge clk) disable iff (rst)
		(state_q == dpfc_pkg::FR_SHIFT && !sync_q[1] && sck_fall && cnt_q == dpfc_pkg::BIT_LAST)
		|=> word_stb && state_q == dpfc_pkg::FR_DONE) // R12
		else $error("word not taken at bit 24");

endmodule : dpfc_serial_rx

`default_nettype wire

// file: design/dpfc_channel_ctrl.sv
// Behaviour
// [R01] Output clamped until supplies good and written
// [R02] Channels power down individually, start down
// [R03] Powered-down channel: pin clamped, amplifier isolated
// [R04] Clamp enable bit picks overcurrent response
// [R05] Clamp mode: alert follows fault, no shutdown
// [R06] Auto mode: fault powers down, sets alert
// [R07] Host re-enables channel; never automatic
// [R08] Thermal shutdown off at reset, bit enables
// [R09] Thermal shutdown sets thermal alert bit
// [R10] Reference off at reset, powered by bit
// [R11] Host keeps reference off with external source
// [R12] 24-bit words sampled on falling clock
// [R13] Link: serial clock, data, frame sync
// [R14] Outputs update automatically or by load strobe
// [R15] Registers readable back over serial link
// [R16] Power register select 010, fixed bit map
// [R17] Thermal shutdown powers down both channels
// [R18] Clamp enable resets set
// [R19] Host waits 10 us before loading output
// [R20] Fault detector inputs synchronised before use
`timescale 1ns/100ps
`default_nettype none

module dpfc_channel_ctrl (
	input  wire logic        clk,             // 10 MHz clock
	input  wire logic        rst,             // Synchronous reset, active high
	input  wire logic        wb_cyc_i,        // Wishbone cycle
	input  wire logic        wb_stb_i,        // Wishbone strobe
	input  wire logic        wb_we_i,         // Wishbone write
	input  wire logic [7:0]  wb_adr_i,        // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,        // Wishbone byte lanes
	input  wire logic [31:0] wb_dat_i,        // Wishbone write data
	output logic      [31:0] wb_dat_o,        // Wishbone read data
	output logic             wb_ack_o,        // Wishbone acknowledge
	input  wire logic        serial_clk,      // Host serial clock
	input  wire logic        frame_sync_n,    // Host frame sync
	input  wire logic        serial_data_in,  // Host serial data
	input  wire logic        load_outputs_n,  // Host load strobe
	output logic             serial_data_out, // Readback data
	input  wire logic [1:0]  oc_detect,       // Overcurrent detectors
	input  wire logic        overtemp_detect, // Overtemperature detector
	input  wire logic        supplies_ok,     // Analog supplies settled
	output logic      [1:0]  chan_powerup,    // Channel powered
	output logic      [1:0]  vout_clamp,      // Output pin clamp to ground
	output logic      [1:0]  amp_connect,     // Amplifier to pin switch
	output logic             vref_powerup,    // Internal reference on
	output logic             device_shutdown, // Thermal shutdown state
	output logic      [15:0] dac_code_a,      // Channel A output code
	output logic      [15:0] dac_code_b       // Channel B output code
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ========================================
	// Helpers
	function automatic int pu_bit(input int ch);
		pu_bit = (ch == 0) ? dpfc_pkg::PU_A : dpfc_pkg::PU_B;
	endfunction : pu_bit

	function automatic logic [2:0] ch_adr(input int ch);
		ch_adr = (ch == 0) ? dpfc_pkg::ADR_CH_A : dpfc_pkg::ADR_CH_B;
	endfunction : ch_adr

	function automatic logic [7:0] ch_wb(input int ch);
		ch_wb = (ch == 0) ? dpfc_pkg::WB_DAC_A : dpfc_pkg::WB_DAC_B;
	endfunction : ch_wb

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	endfunction : merge16

	// ========================================
	// Detector synchronisers
	logic [3:0] det_meta_q;
	logic [3:0] det_sync_q;
	logic [1:0] oc_s;
	logic       ot_s;
	logic       sup_s;

	always_ff @(posedge clk) begin
		if (rst) begin
			det_meta_q <= 4'h0;
			det_sync_q <= 4'h0;
		end else begin
			det_meta_q <= {supplies_ok, overtemp_detect, oc_detect}; // R20
			det_sync_q <= det_meta_q;                              // R20
		end
	end

	assign oc_s  = det_sync_q[1:0];
	assign ot_s  = det_sync_q[2];
	assign sup_s = det_sync_q[3];

	// ========================================
	// Serial link
	logic [23:0] rx_word;
	logic        rx_stb;
	logic        load_s;
	logic [23:0] tx_word;
	logic        sdo_off_q;

	dpfc_serial_rx u_rx (
		.clk            (clk),
		.rst            (rst),
		.serial_clk     (serial_clk),
		.frame_sync_n   (frame_sync_n),
		.serial_data_in (serial_data_in),
		.load_outputs_n (load_outputs_n),
		.tx_word        (tx_word),
		.tx_en          (~sdo_off_q),
		.word           (rx_word),
		.word_stb       (rx_stb),
		.load_s         (load_s),
		.serial_data_out(serial_data_out)
	); // R13

	logic        rx_wr;
	logic        rx_rd;
	logic [2:0]  rx_reg;
	logic [2:0]  rx_adr;
	logic [15:0] rx_dat;

	assign rx_wr  = rx_stb & ~rx_word[dpfc_pkg::RW_POS];
	assign rx_rd  = rx_stb & rx_word[dpfc_pkg::RW_POS];
	assign rx_reg = rx_word[dpfc_pkg::REG_HI:dpfc_pkg::REG_LO];
	assign rx_adr = rx_word[dpfc_pkg::ADR_HI:dpfc_pkg::ADR_LO];
	assign rx_dat = rx_word[dpfc_pkg::DAT_W-1:0];

	// ========================================
	// Wishbone decode; a serial write beats a bus write in the same cycle
	logic        ack_q;
	logic        wb_wr;
	logic        pwr_wr;
	logic [15:0] pwr_val;
	logic        cfg_wr;
	logic [15:0] cfg_val;
	logic        s_pwr;
	logic        s_cfg;
	logic        s_load;

	assign wb_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign s_pwr   = rx_wr & (rx_reg == dpfc_pkg::REG_PWR); // R16
	assign s_cfg   = rx_wr & (rx_reg == dpfc_pkg::REG_CTRL) & (rx_adr == dpfc_pkg::ADR_CFG);
	assign s_load  = rx_wr & (rx_reg == dpfc_pkg::REG_CTRL) & (rx_adr == dpfc_pkg::ADR_LOAD);
	assign pwr_wr  = s_pwr | (wb_wr & (wb_adr_i == dpfc_pkg::WB_PWR) & wb_sel_i[0]);
	assign pwr_val = s_pwr ? rx_dat : wb_dat_i[15:0];
	assign cfg_wr  = s_cfg | (wb_wr & (wb_adr_i == dpfc_pkg::WB_CTRL) & wb_sel_i[0]);
	assign cfg_val = s_cfg ? rx_dat : wb_dat_i[15:0];

	// ========================================
	// Configuration
	logic clamp_en_q;
	logic tsd_en_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			clamp_en_q <= dpfc_pkg::CLMP_RST; // R18
			tsd_en_q   <= dpfc_pkg::TSD_RST;  // R08
			sdo_off_q  <= dpfc_pkg::SDO_RST;
		end else if (cfg_wr) begin
			clamp_en_q <= cfg_val[dpfc_pkg::CFG_CLMP]; // R04
			tsd_en_q   <= cfg_val[dpfc_pkg::CFG_TSD];
			sdo_off_q  <= cfg_val[dpfc_pkg::CFG_SDO];
		end
	end

	// ========================================
	// Power, overcurrent and thermal state
	logic [1:0] pu_q;
	logic [1:0] oc_q;
	logic       ta_q;
	logic       vref_q;
	logic       tshut;

	assign tshut = tsd_en_q & ot_s; // R08

	always_ff @(posedge clk) begin
		if (rst) begin
			pu_q <= 2'h0; // R02
			oc_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// Faults win over a host write landing in the same cycle
				if (tshut) begin
					pu_q[i] <= 1'b0; // R17
				end else if (oc_s[i] && !clamp_en_q && pu_q[i]) begin
					pu_q[i] <= 1'b0; // R06
				end else if (pwr_wr) begin
					pu_q[i] <= pwr_val[pu_bit(i)]; // R02
				end
				if (clamp_en_q) begin
					oc_q[i] <= oc_s[i]; // R05
				end else if (oc_s[i] && pu_q[i]) begin
					oc_q[i] <= 1'b1; // R06
				end else if (pwr_wr && pwr_val[pu_bit(i)]) begin
					oc_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ta_q <= 1'b0;
		end else if (tshut) begin
			ta_q <= 1'b1; // R09
		end else if (pwr_wr) begin
			ta_q <= 1'b0;
		end
	end

	// Reference follows its bit and is cleared by thermal shutdown; an external reference relies on the host
	always_ff @(posedge clk) begin
		if (rst) begin
			vref_q <= 1'b0; // R10
		end else if (tshut) begin
			vref_q <= 1'b0;
		end else if (pwr_wr) begin
			vref_q <= pwr_val[dpfc_pkg::VREF_POWERUP]; // R10
		end
	end

	// ========================================
	// DAC input and output registers
	logic [15:0] din_q  [2];
	logic [15:0] dout_q [2];
	logic [1:0]  valid_q;
	logic [1:0]  hit;
	logic [1:0]  s_hit;
	logic [15:0] hit_val [2];
	logic        load_prev_q;
	logic        upd_all;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			s_hit[i] = rx_wr & (rx_reg == dpfc_pkg::REG_DAC)
				& ((rx_adr == ch_adr(i)) | (rx_adr == dpfc_pkg::ADR_BOTH));
			hit[i] = s_hit[i] | (wb_wr & (wb_adr_i == ch_wb(i)));
			hit_val[i] = s_hit[i] ? rx_dat : merge16(din_q[i], wb_dat_i, wb_sel_i);
		end
	end

	assign upd_all = s_load | (load_prev_q & ~load_s); // R14

	always_ff @(posedge clk) begin
		if (rst) begin
			load_prev_q <= 1'b1;
		end else begin
			load_prev_q <= load_s;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			din_q   <= '{2{16'h0000}};
			dout_q  <= '{2{16'h0000}};
			valid_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (hit[i]) begin
					din_q[i]   <= hit_val[i];
					valid_q[i] <= 1'b1; // R01
				end
				// Strobe held low means every word goes straight out
				if (hit[i] && !load_s) begin
					dout_q[i] <= hit_val[i]; // R14
				end else if (upd_all) begin
					dout_q[i] <= din_q[i]; // R14
				end
			end
		end
	end

	// ========================================
	// Output switches
	logic [1:0] clamp_q;
	logic [1:0] amp_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			clamp_q <= 2'h3;
			amp_q   <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				clamp_q[i] <= ~(pu_q[i] & valid_q[i] & sup_s); // R01 R03
				amp_q[i]   <= pu_q[i] & valid_q[i] & sup_s;    // R01 R03
			end
		end
	end

	// ========================================
	// Register views, serial readback and bus reads
	logic [15:0] pwr_view;
	logic [15:0] cfg_view;
	logic [15:0] rb_view;
	logic [5:0]  rb_q;

	always_comb begin
		pwr_view = 16'h0000;
		pwr_view[dpfc_pkg::PU_A]   = pu_q[0]; // R16
		pwr_view[dpfc_pkg::PU_B]   = pu_q[1];
		pwr_view[dpfc_pkg::VREF_POWERUP] = vref_q;
		pwr_view[dpfc_pkg::TALERT] = ta_q;
		pwr_view[dpfc_pkg::OC_A]   = oc_q[0];
		pwr_view[dpfc_pkg::OC_B]   = oc_q[1];
		cfg_view = 16'h0000;
		cfg_view[dpfc_pkg::CFG_SDO]  = sdo_off_q;
		cfg_view[dpfc_pkg::CFG_CLMP] = clamp_en_q;
		cfg_view[dpfc_pkg::CFG_TSD]  = tsd_en_q;
		case (rb_q[5:3])
			dpfc_pkg::REG_DAC: begin
				rb_view = (rb_q[2:0] == dpfc_pkg::ADR_CH_B) ? din_q[1] : din_q[0];
			end
			dpfc_pkg::REG_PWR: begin
				rb_view = pwr_view;
			end
			dpfc_pkg::REG_CTRL: begin
				rb_view = cfg_view;
			end
			default: begin
				rb_view = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rb_q <= 6'h00;
		end else if (rx_rd) begin
			rb_q <= {rx_reg, rx_adr}; // R15
		end
	end

	assign tx_word = {2'h2, rb_q, rb_view}; // R15

	logic [31:0] rd_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			rd_q  <= 32'h00000000;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
			rd_q  <= 32'h00000000;
			case (wb_adr_i)
				dpfc_pkg::WB_DAC_A: rd_q[15:0] <= din_q[0];
				dpfc_pkg::WB_DAC_B: rd_q[15:0] <= din_q[1];
				dpfc_pkg::WB_PWR:   rd_q[15:0] <= pwr_view;
				dpfc_pkg::WB_CTRL:  rd_q[15:0] <= cfg_view;
				dpfc_pkg::WB_STAT: begin
					rd_q[dpfc_pkg::ST_SUP]                   <= sup_s;
					rd_q[dpfc_pkg::ST_OT]                    <= ot_s;
					rd_q[dpfc_pkg::ST_VALID+:2]              <= valid_q;
					rd_q[dpfc_pkg::ST_CLAMP+:2]              <= clamp_q;
					rd_q[dpfc_pkg::ST_OCRAW+:2]              <= oc_s;
				end
				default: rd_q <= 32'h00000000;
			endcase
		end
	end

	assign wb_dat_o        = rd_q;
	assign wb_ack_o        = ack_q;
	assign chan_powerup    = pu_q;
	assign vout_clamp      = clamp_q;
	assign amp_connect     = amp_q;
	assign vref_powerup    = vref_q;
	assign device_shutdown = ta_q;
	assign dac_code_a      = dout_q[0];
	assign dac_code_b      = dout_q[1];

	// ========================================
	// Checks
	a_reset_state: assert property ($fell(rst) |->
		pu_q == 2'h0 && !vref_q && clamp_en_q && !tsd_en_q && clamp_q == 2'h3) // R02 R08 R10 R18
		else $error("reset state wrong");

	a_clamp_unwritten: assert property (!valid_q[0] |=> vout_clamp[0] && !amp_connect[0]) // R01
		else $error("channel A released before a valid write");

	a_clamp_powerdown: assert property (!pu_q[1] |=> vout_clamp[1] && !amp_connect[1]) // R03
		else $error("powered-down channel B not clamped");

	a_auto_powerdown: assert property ((oc_s[0] && !clamp_en_q && pu_q[0])
		|=> !chan_powerup[0] && oc_q[0]) // R04 R06
		else $error("overcurrent did not power channel A down");

	a_clamp_mode: assert property ((clamp_en_q && !tshut && !pwr_wr && pu_q[1])
		|=> pu_q[1] && oc_q[1] == $past(oc_s[1])) // R04 R05
		else $error("clamp mode alert or power wrong");

	a_tsd_disabled: assert property (!tsd_en_q |=> !$rose(ta_q)) // R08
		else $error("thermal alert while shutdown disabled");

	a_thermal_event: assert property ((tsd_en_q && ot_s)
		|=> ta_q && chan_powerup == 2'h0 && !vref_powerup) // R09 R17
		else $error("thermal shutdown incomplete");

	a_oc_sync_delay: assert property ((det_meta_q[0] == 1'b0 && det_sync_q[0] == 1'b0
		&& !clamp_en_q) |=> !$rose(oc_q[0])) // R20
		else $error("overcurrent acted before synchronisation");

	a_auto_update: assert property ((hit[0] && !load_s) |=> dac_code_a == $past(hit_val[0])) // R14
		else $error("channel A output not updated");

	a_readback_word: assert property (rx_rd |=> tx_word[21:16] == $past(rx_word[21:16])) // R15
		else $error("readback select not captured");

endmodule : dpfc_channel_ctrl

`default_nettype wire

// file: verification/dpfc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module dpfc_host_model (
	input  wire logic clk,            // System clock
	output logic      serial_clk,     // Link clock, stands low between frames
	output logic      frame_sync_n,   // Frame sync, low in frame
	output logic      serial_data_in, // Data to device
	input  wire logic serial_data_out // Readback from device
);
	initial begin
		serial_clk = 1'b0;
		frame_sync_n = 1'b1;
		serial_data_in = 1'b0;
	end

	// ========================================
	// One frame, MSB first, 800 ns link period
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		repeat (2) @(posedge clk);
		frame_sync_n <= 1'b0;
		repeat (6) @(posedge clk);
		for (int i = 23; i >= 0; i--) begin
			r[i] = serial_data_out;
			serial_clk <= 1'b1;
			serial_data_in <= w[i];
			repeat (4) @(posedge clk);
			serial_clk <= 1'b0;
			repeat (4) @(posedge clk);
		end
		// Idle line must not keep showing the last bit
		serial_data_in <= ~w[0];
		frame_sync_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : xfer
endmodule : dpfc_host_model
`default_nettype wire

// file: verification/dpfc_channel_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dpfc_channel_ctrl_tb;
	logic        clk;
	logic        rst;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        serial_clk;
	logic        frame_sync_n;
	logic        serial_data_in;
	logic        load_outputs_n;
	logic        serial_data_out;
	logic [1:0]  oc_detect;
	logic        overtemp_detect;
	logic        supplies_ok;
	logic [1:0]  chan_powerup;
	logic [1:0]  vout_clamp;
	logic [1:0]  amp_connect;
	logic        vref_powerup;
	logic        device_shutdown;
	logic [15:0] dac_code_a;
	logic [15:0] dac_code_b;
	logic [23:0] rd;
	int          mismatches;
	int          total_checks;

	dpfc_channel_ctrl i_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clk(serial_clk),
		.frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
		.load_outputs_n(load_outputs_n), .serial_data_out(serial_data_out),
		.oc_detect(oc_detect), .overtemp_detect(overtemp_detect), .supplies_ok(supplies_ok),
		.chan_powerup(chan_powerup), .vout_clamp(vout_clamp), .amp_connect(amp_connect),
		.vref_powerup(vref_powerup), .device_shutdown(device_shutdown),
		.dac_code_a(dac_code_a), .dac_code_b(dac_code_b));

	dpfc_host_model i_host (.clk(clk), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ========================================
	// Helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	// Classic cycle: hold until ack is sampled, then release for one cycle
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) mismatches++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk);
	endtask : wb_xfer

	task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb_xfer(1'b1, adr, dat, q);
	endtask : wb_wr

	task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb_xfer(1'b0, adr, 32'h0, q);
		check(q, exp);
	endtask : wb_rd

	initial begin
		tick(20000);
		mismatches++;
		complete_run;
	end

	// ========================================
	// Tests
	initial begin
		mismatches = 0;
		total_checks = 0;
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h3;
		wb_dat_i = 32'h0;
		load_outputs_n = 1'b1;
		oc_detect = 2'h0;
		overtemp_detect = 1'b0;
		supplies_ok = 1'b0;
		tick(12);
		rst <= 1'b0;
		tick(3);
		wb_rd(dpfc_pkg::WB_PWR, 32'h0);
		wb_rd(dpfc_pkg::WB_CTRL, 32'h4);
		wb_rd(8'h20, 32'h0);
		check(32'(vout_clamp), 32'h3);
		check(32'(amp_connect), 32'h0);
		check(32'(vref_powerup), 32'h0);
		supplies_ok <= 1'b1;
		wb_wr(dpfc_pkg::WB_PWR, 32'h1);
		tick(100);
		check(32'(vout_clamp), 32'h3);
		load_outputs_n <= 1'b0;
		i_host.xfer(24'h001234, rd);
		tick(4);
		check(32'(dac_code_a), 32'h1234);
		check(32'(vout_clamp), 32'h2);
		check(32'(amp_connect), 32'h1);
		// Deferred update: word waits for the strobe
		load_outputs_n <= 1'b1;
		i_host.xfer(24'h02beef, rd);
		tick(4);
		check(32'(dac_code_b), 32'h0);
		load_outputs_n <= 1'b0;
		tick(6);
		check(32'(dac_code_b), 32'hbeef);
		load_outputs_n <= 1'b1;
		oc_detect <= 2'h1;
		tick(8);
		wb_rd(dpfc_pkg::WB_PWR, 32'h81);
		oc_detect <= 2'h0;
		tick(8);
		wb_rd(dpfc_pkg::WB_PWR, 32'h1);
		wb_wr(dpfc_pkg::WB_CTRL, 32'h0);
		oc_detect <= 2'h1;
		tick(1);
		check(32'(chan_powerup), 32'h1);
		tick(8);
		wb_rd(dpfc_pkg::WB_PWR, 32'h80);
		check(32'(vout_clamp), 32'h3);
		oc_detect <= 2'h0;
		tick(20);
		check(32'(chan_powerup), 32'h0);
		wb_wr(dpfc_pkg::WB_PWR, 32'h1);
		wb_rd(dpfc_pkg::WB_PWR, 32'h1);
		wb_wr(dpfc_pkg::WB_PWR, 32'h15);
		check(32'(vref_powerup), 32'h1);
		overtemp_detect <= 1'b1;
		tick(8);
		check(32'(device_shutdown), 32'h0);
		wb_wr(dpfc_pkg::WB_CTRL, 32'h8);
		tick(6);
		check(32'(device_shutdown), 32'h1);
		check(32'(chan_powerup), 32'h0);
		wb_rd(dpfc_pkg::WB_PWR, 32'h20);
		overtemp_detect <= 1'b0;
		tick(6);
		wb_wr(dpfc_pkg::WB_PWR, 32'h0);
		wb_rd(dpfc_pkg::WB_PWR, 32'h0);
		i_host.xfer(24'h100005, rd);
		tick(4);
		check(32'(chan_powerup), 32'h3);
		i_host.xfer(24'h900000, rd);
		i_host.xfer(24'h900000, rd);
		check(32'(rd), 32'h900005);
		supplies_ok <= 1'b0;
		tick(6);
		check(32'(vout_clamp), 32'h3);
		wb_rd(dpfc_pkg::WB_STAT, 32'h3c);
		complete_run;
	end
endmodule : dpfc_channel_ctrl_tb
`default_nettype wire
